// file: hw/ssp_pkg.sv
// Shared constants of the clock synthesizer serial programmer: field layout,
// power-up values, framing pattern, register offsets of the host end and timing.
// Assumes a single 200 MHz system clock on both ends.
package ssp_pkg;

    // System clock
    localparam int CLK_PERIOD_NS = 5;

    // Synthesizer control word
    localparam int         CTRL_BITS      = 8;
    localparam int         CTRL_PROG_EN   = 0;       // Program word register enable
    localparam int         CTRL_OUT_DIS   = 1;       // Output tri-state
    localparam int         CTRL_MUX_REF   = 2;       // Output mux selects reference
    localparam logic [7:0] CTRL_RESET     = 8'h04;   // Power-up control value
    localparam int         PROTO_BITS     = 6;
    localparam logic [5:0] PROTO_FIELD    = 6'h1E;   // 011110, same read either way
    localparam int         CTRL_XFER_BITS = 14;

    // Programming word layout
    localparam int          WORD_BITS   = 22;
    localparam int          P_LSB       = 15;
    localparam int          P_BITS      = 7;
    localparam int          DUTY_BIT    = 14;
    localparam int          M_LSB       = 11;
    localparam int          M_BITS      = 3;
    localparam int          Q_LSB       = 4;
    localparam int          Q_BITS      = 7;
    localparam int          IDX_LSB     = 0;
    localparam int          IDX_BITS    = 4;
    localparam int          STUFF_RUN   = 3;         // Ones before a stuffed zero
    localparam logic [21:0] WORD_RESET  = 22'h000000;
    localparam logic [8:0]  P_OFFSET    = 9'h003;
    localparam logic [7:0]  Q_OFFSET    = 8'h02;
    localparam int          REF_FREQ_HZ = 14318180;  // Reference oscillator

    // Host register word (frequency/gain register)
    localparam int         HW_DATA_BITS = 27;
    localparam int         HW_LEN_LSB   = 27;
    localparam logic [2:0] HW_LEN_CTRL  = 3'h7;      // All set marks a control word
    localparam int         HW_DEST_LSB  = 30;
    localparam logic [1:0] DEST_NONE    = 2'h0;
    localparam logic [1:0] DEST_SAMPLE  = 2'h1;      // Sampling clock oscillator
    localparam logic [1:0] DEST_STROBE  = 2'h2;      // Data-port strobe oscillator

    // Host Wishbone register map
    localparam logic [3:0] REG_WORD   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam int         ST_BUSY    = 0;
    localparam int         ST_SETTLE  = 1;
    localparam int         ST_REFUSED = 2;

    // Link timing
    localparam int SCLK_HALF_NS  = 50;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_MS     = 10;
    localparam int SETTLE_CYC    = (SETTLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : ssp_pkg

// file: hw/ssp_link_if.sv
// Serial link between board host logic and the clock synthesizer.
// Assumes the host end drives every signal; the synth end only listens.
`timescale 1ns/100ps
`default_nettype none
interface ssp_link_if;
    logic       sclk;   // Serial clock made by the host divider
    logic       sdata;  // Serial data, changes while sclk is low
    logic [1:0] dest;   // Target oscillator, nonzero only during a transfer

    modport host  (output sclk, output sdata, output dest);
    modport synth (input sclk, input sdata, input dest);
endinterface : ssp_link_if
`default_nettype wire

// file: hw/ssp_synth_end.sv
// Clock synthesizer end: serial receiver, control register, programming word
// register with bit destuffing, and the frequency settings it presents.
// Assumes the link pins come from outside this clock domain and are synchronised.
//
// Notes on behaviour
// - Control bit 1 tri-states the output.
// - Control bit 2 routes reference, else VCO.
// - Control transfer: 8 bits up, then protocol.
// - Power-up output is the reference frequency.
// - Sender stuffs zero after three ones.
// - Ones run carries across field boundaries.
// - Word fields P, D, M, Q, Index.
// - VCO is 2 times ref times (P+3)/(Q+2).
// - Output is VCO divided by two^M.
// - Host keeps VCO within 50 to 150 MHz.
// - Host picks Index by VCO range.
// - Clearing enable commits, reference stays out.
// - Host waits 10 ms before switching over.
// - Clearing mux bit switches output at once.
// - Register bits 31:30 pick target oscillator.
// - Protocol 011110; four ones nowhere else.
// - Register shifted out least significant first.
// - Length bits beyond 22; all set for control.
// - Control bit 0 lets word register accept.
`timescale 1ns/100ps
`default_nettype none
module ssp_synth_end
    import ssp_pkg::*;
#(
    parameter logic [1:0] DEST_ID = DEST_SAMPLE   // Which oscillator this end is
) (
    input  wire logic           clk_sys,
    input  wire logic           reset_n,
    ssp_link_if.synth           link,
    output logic                out_oe_n,       // Low while the output drives
    output logic                out_sel_ref,    // High while reference is routed out
    output logic [7:0]          ctrl_word,      // Control register contents
    output logic                word_loaded,    // A full word waits for commit
    output logic [P_BITS-1:0]   prog_p,
    output logic [Q_BITS-1:0]   prog_q,
    output logic [M_BITS-1:0]   prog_m,
    output logic [IDX_BITS-1:0] prog_index,
    output logic [8:0]          vco_mult,       // 2*(P+3), times reference
    output logic [7:0]          vco_div,        // Q+2, divides reference product
    output logic [7:0]          out_div         // 2^M after the VCO
);

    // Two-stage synchronisers; the third stage only serves the edge detector
    logic       sclk_s1_q;
    logic       sclk_s2_q;
    logic       sclk_s3_q;
    logic       sdata_s1_q;
    logic       sdata_s2_q;
    logic [1:0] dest_s1_q;
    logic [1:0] dest_s2_q;

    // Receiver state
    logic [CTRL_XFER_BITS-1:0] hist_q;
    logic [CTRL_XFER_BITS-1:0] hist_d;
    logic [1:0]                ones_q;
    logic [WORD_BITS-1:0]      word_sh_q;
    logic [4:0]                word_cnt_q;
    logic [7:0]                ctrl_q;
    logic [WORD_BITS-1:0]      active_q;

    // Decoded strobes
    logic bit_stb;
    logic ctrl_hit;
    logic stuff_bit;
    logic word_full;
    logic take_bit;
    logic commit;

    // Link pins cross into the system clock domain
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sclk_s1_q  <= 1'b0;
            sclk_s2_q  <= 1'b0;
            sclk_s3_q  <= 1'b0;
            sdata_s1_q <= 1'b0;
            sdata_s2_q <= 1'b0;
            dest_s1_q  <= DEST_NONE;
            dest_s2_q  <= DEST_NONE;
        end else begin
            sclk_s1_q  <= link.sclk;
            sclk_s2_q  <= sclk_s1_q;
            sclk_s3_q  <= sclk_s2_q;
            sdata_s1_q <= link.sdata;
            sdata_s2_q <= sdata_s1_q;
            dest_s1_q  <= link.dest;
            dest_s2_q  <= dest_s1_q;
        end
    end

    // A bit is taken on each rising serial clock aimed at this oscillator
    assign bit_stb = sclk_s2_q & ~sclk_s3_q & (dest_s2_q == DEST_ID);

    // Newest bit enters at the top, so after 14 bits the control byte sits low
    assign hist_d = {sdata_s2_q, hist_q[CTRL_XFER_BITS-1:1]};

    // The protocol field is the only place four ones may stand together,
    // so its pattern in the last six bits marks a control transfer
    assign ctrl_hit = bit_stb
                    & (hist_d[CTRL_XFER_BITS-1:CTRL_BITS] == PROTO_FIELD);

    // A bit after three ones is a stuffed zero and carries no data
    assign stuff_bit = (ones_q == 2'(STUFF_RUN));
    assign word_full = (word_cnt_q == 5'(WORD_BITS));

    // Data bits reach the word register only while enabled and not yet full
    assign take_bit = bit_stb & ~ctrl_hit & ~stuff_bit & ~word_full
                    & ctrl_q[CTRL_PROG_EN];

    // Enable falling with a complete word commits it
    assign commit = ctrl_hit & ctrl_q[CTRL_PROG_EN]
                  & ~hist_d[CTRL_PROG_EN] & word_full;

    // History of raw serial bits for framing
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            hist_q <= '0;
        end else if (bit_stb) begin
            hist_q <= hist_d;
        end
    end

    // Run of ones on the raw stream; it never restarts at a field boundary
    // because the sender counts the same way across fields
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ones_q <= 2'h0;
        end else if (ctrl_hit) begin
            ones_q <= 2'h0;
        end else if (bit_stb) begin
            if (stuff_bit || !sdata_s2_q) begin
                ones_q <= 2'h0;
            end else begin
                ones_q <= ones_q + 2'h1;
            end
        end
    end

    // Destuffed word assembly, least significant bit first
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            word_sh_q  <= WORD_RESET;
            word_cnt_q <= 5'h00;
        end else if (ctrl_hit) begin
            // A new control word always opens a fresh word load
            word_cnt_q <= 5'h00;
        end else if (take_bit) begin
            word_sh_q  <= {sdata_s2_q, word_sh_q[WORD_BITS-1:1]};
            word_cnt_q <= word_cnt_q + 5'h01;
        end
    end

    // Control register; reserved bits are kept but steer nothing
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (ctrl_hit) begin
            ctrl_q <= hist_d[CTRL_BITS-1:0];
        end
    end

    // Committed programming word; load alone never disturbs the VCO
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            active_q <= WORD_RESET;
        end else if (commit) begin
            active_q <= word_sh_q;
        end
    end

    // Output path follows the control register at once
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            out_oe_n    <= 1'b0;
            out_sel_ref <= 1'b1;
            ctrl_word   <= CTRL_RESET;
        end else begin
            out_oe_n    <= ctrl_q[CTRL_OUT_DIS];
            out_sel_ref <= ctrl_q[CTRL_MUX_REF];
            ctrl_word   <= ctrl_q;
        end
    end

    // Word fields and frequency ratios; the duty bit is ignored, being zero
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            prog_p      <= '0;
            prog_q      <= '0;
            prog_m      <= '0;
            prog_index  <= '0;
            vco_mult    <= 9'h000;
            vco_div     <= 8'h00;
            out_div     <= 8'h01;
            word_loaded <= 1'b0;
        end else begin
            prog_p      <= active_q[P_LSB +: P_BITS];
            prog_q      <= active_q[Q_LSB +: Q_BITS];
            prog_m      <= active_q[M_LSB +: M_BITS];
            prog_index  <= active_q[IDX_LSB +: IDX_BITS];
            // Product stays within nine bits: (127+3)*2 = 260
            vco_mult    <= 9'(({2'b00, active_q[P_LSB +: P_BITS]} + P_OFFSET) << 1);
            vco_div     <= {1'b0, active_q[Q_LSB +: Q_BITS]} + Q_OFFSET;
            out_div     <= 8'(8'h01 << active_q[M_LSB +: M_BITS]);
            word_loaded <= word_full;
        end
    end

endmodule : ssp_synth_end
`default_nettype wire

// file: hw/ssp_host_end.sv
// Board host end: Wishbone classic slave holding the frequency register, and
// the shifter that sends its data bits serially to the selected oscillator.
// Assumes software builds stuffed words and waits on the busy bit.
`timescale 1ns/100ps
`default_nettype none
module ssp_host_end
    import ssp_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC,    // VCO settle wait
    parameter int HALF_CYCLES   = SCLK_HALF_CYC  // Half period of serial clock
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    ssp_link_if.host         link
);

    logic [HW_DATA_BITS-1:0] shreg_q;
    logic [4:0]              left_q;
    logic [31:0]             div_q;
    logic [31:0]             settle_q;
    logic                    busy_q;
    logic                    refused_q;
    logic                    commit_pend_q;
    logic                    req;
    logic                    wr_word;
    logic                    is_ctrl;
    logic                    refuse;
    logic                    start;
    logic                    tick;
    logic                    last;

    assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_word = req & wb_we_i & (wb_adr_i == REG_WORD) & (wb_sel_i == 4'hF);
    assign is_ctrl = (wb_dat_i[HW_LEN_LSB +: 3] == HW_LEN_CTRL);
    // Switching to the VCO before it settles, or writing mid-transfer, is refused
    assign refuse  = wr_word & (busy_q
                   | (is_ctrl & ~wb_dat_i[CTRL_MUX_REF] & (settle_q != 0)));
    assign start   = wr_word & ~refuse;
    assign tick    = busy_q & (div_q == 32'(HALF_CYCLES - 1));
    assign last    = tick & link.sclk & (left_q == 5'h01);

    // Bus answer one cycle after the request, dropped the next cycle
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h00000000;
            if (req && !wb_we_i && wb_adr_i == REG_STATUS) begin
                wb_dat_o[ST_BUSY]    <= busy_q;
                wb_dat_o[ST_SETTLE]  <= (settle_q != 0);
                wb_dat_o[ST_REFUSED] <= refused_q;
            end
        end
    end

    // Refusal flag: a new refusal wins over a write-one clear
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            refused_q <= 1'b0;
        end else if (refuse) begin
            refused_q <= 1'b1;
        end else if (req && wb_we_i && wb_adr_i == REG_STATUS && wb_sel_i[0] && wb_dat_i[ST_REFUSED]) begin
            refused_q <= 1'b0;
        end
    end

    // Divider makes the half-period enable while shifting
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !busy_q || tick) begin
            div_q <= 32'h00000000;
        end else begin
            div_q <= div_q + 32'h00000001;
        end
    end

    // Shifter: data set while clock low, clock rises mid-bit, next bit on fall
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            busy_q     <= 1'b0;
            shreg_q    <= '0;
            left_q     <= 5'h00;
            link.sclk  <= 1'b0;
            link.sdata <= 1'b0;
            link.dest  <= DEST_NONE;
        end else if (start) begin
            busy_q     <= 1'b1;
            // Control words carry no stuffing and zero reserved bits; data
            // words are sent as software stuffed them
            shreg_q    <= is_ctrl ? {13'h0000, wb_dat_i[13:8], 5'h00, wb_dat_i[2:0]}
                                  : wb_dat_i[HW_DATA_BITS-1:0];
            left_q     <= is_ctrl ? 5'(CTRL_XFER_BITS) : 5'(WORD_BITS) + {2'b00, wb_dat_i[HW_LEN_LSB +: 3]};
            link.sdata <= wb_dat_i[0];
            link.dest  <= wb_dat_i[HW_DEST_LSB +: 2];
            link.sclk  <= 1'b0;
        end else if (tick) begin
            link.sclk <= ~link.sclk;
            if (link.sclk) begin
                left_q <= left_q - 5'h01;
                if (last) begin
                    busy_q    <= 1'b0;
                    link.dest <= DEST_NONE;
                end else begin
                    link.sdata <= shreg_q[1];
                    shreg_q    <= shreg_q >> 1;
                end
            end
        end
    end

    // Settle timer starts when a commit control word has been shifted
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            commit_pend_q <= 1'b0;
            settle_q      <= 32'h00000000;
        end else begin
            if (start) begin
                commit_pend_q <= is_ctrl & ~wb_dat_i[CTRL_PROG_EN];
            end
            if (last && commit_pend_q) begin
                settle_q <= 32'(SETTLE_CYCLES);
            end else if (settle_q != 0) begin
                settle_q <= settle_q - 32'h00000001;
            end
        end
    end

endmodule : ssp_host_end
`default_nettype wire

// file: tb/ssp_link_sva.sv
// Checker for the serial link joining the host end to the synthesizer ends.
// Assumes it watches the plain link signals in the single clk_sys domain.
`timescale 1ns/100ps
`default_nettype none
module ssp_link_sva
    import ssp_pkg::*;
#(
    parameter int HALF_CYCLES = SCLK_HALF_CYC
) (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       sclk,
    input wire logic       sdata,
    input wire logic [1:0] dest
);
    logic [7:0] hi_q, lo_q;
    logic [5:0] nb_q, tail_q;
    logic [2:0] run_q;
    logic       sclk_q;
    logic       rise;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Rising serial clock as the receiver sees it
    assign rise = sclk && !sclk_q;
    always_ff @(posedge clk_sys) begin
        sclk_q <= reset_n ? sclk : 1'b0;
    end

    // Phase lengths; low phase counted only inside a transfer
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            hi_q <= 8'h00;
            lo_q <= 8'h00;
        end else begin
            hi_q <= sclk ? hi_q + 8'h01 : 8'h00;
            lo_q <= (sclk || dest == 2'h0) ? 8'h00 : lo_q + 8'h01;
        end
    end

    // Bit count, last six bits and run of ones within one transfer
    always_ff @(posedge clk_sys) begin
        if (!reset_n || dest == 2'h0) begin
            nb_q   <= 6'h00;
            tail_q <= 6'h00;
            run_q  <= 3'h0;
        end else if (rise) begin
            nb_q   <= nb_q + 6'h01;
            tail_q <= {tail_q[4:0], sdata};
            run_q  <= sdata ? run_q + 3'h1 : 3'h0;
        end
    end

    idle_clock_a: assert property (dest == 2'h0 |-> !sclk)
        else $error("serial clock moves outside a transfer");
    data_on_fall_a: assert property ($changed(sdata) && dest != 2'h0 && $past(dest) != 2'h0 |-> $fell(sclk))
        else $error("serial data changes away from a falling clock");
    dest_steady_a: assert property (dest != 2'h0 && $past(dest) != 2'h0 |-> $stable(dest))
        else $error("target changes inside a transfer");
    high_len_a: assert property ($fell(sclk) |-> hi_q == 8'(HALF_CYCLES))
        else $error("serial clock high phase has wrong length");
    low_len_a: assert property ($rose(sclk) |-> lo_q == 8'(HALF_CYCLES))
        else $error("serial clock low phase has wrong length");
    frame_len_a: assert property (dest == 2'h0 && $past(dest) != 2'h0 |-> nb_q == 6'h0E || (nb_q >= 6'h16 && nb_q <= 6'h1D))
        else $error("transfer has an illegal bit count");
    proto_tail_a: assert property (dest == 2'h0 && $past(dest) != 2'h0 && nb_q == 6'h0E |-> tail_q == PROTO_FIELD)
        else $error("control transfer lacks the protocol field");
    ones_run_a: assert property (rise && sdata && run_q == 3'h3 |-> nb_q == 6'h0C)
        else $error("four ones outside the protocol field");
    xfer_bound_a: assert property ($rose(dest != 2'h0) |-> ##[1:1000] dest == 2'h0)
        else $error("transfer does not end");

    // Main traffic kinds
    cover property (dest == 2'h0 && $past(dest) != 2'h0 && nb_q == 6'h0E);
    cover property (dest == 2'h0 && $past(dest) != 2'h0 && nb_q > 6'h16);
    cover property (rise && sdata && run_q == 3'h3);
endmodule : ssp_link_sva
`default_nettype wire

// file: tb/synth_serial_programmer_tb_top.sv
// Bench for the serial programmer: host end and two synthesizer ends on one link.
// Assumes a 200 MHz clock; settle and serial clock counts are shortened for run time.
`timescale 1ns/100ps
`default_nettype none
module synth_serial_programmer_tb_top
    import ssp_pkg::*;
;
    localparam int HALF   = 3;
    localparam int SETTLE = 50;

    logic        clk_sys = 1'b0;
    logic        reset_n, wb_cyc, wb_stb, wb_we, wb_ack, word_loaded, out_oe_n, out_sel_ref;
    logic [3:0]  wb_adr, wb_sel, prog_index;
    logic [31:0] wb_dat, wb_rdat, st;
    logic [7:0]  ctrl_word, strobe_ctrl, vco_div, out_div;
    logic [6:0]  prog_p, prog_q;
    logic [2:0]  prog_m;
    logic [8:0]  vco_mult;
    logic [28:0] sw;
    int          sn, n_fail = 0, comparisons = 0;
    logic        rx_bits[$];

    ssp_link_if link ();

    // Clock; all stimulus moves on its rising edge
    always #(CLK_PERIOD_NS / 2.0) clk_sys = ~clk_sys;

    ssp_host_end #(.SETTLE_CYCLES(SETTLE), .HALF_CYCLES(HALF)) ssp_host_end_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .link(link));
    ssp_synth_end #(.DEST_ID(DEST_SAMPLE)) ssp_synth_end_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .link(link), .out_oe_n(out_oe_n), .out_sel_ref(out_sel_ref),
        .ctrl_word(ctrl_word), .word_loaded(word_loaded), .prog_p(prog_p), .prog_q(prog_q), .prog_m(prog_m),
        .prog_index(prog_index), .vco_mult(vco_mult), .vco_div(vco_div), .out_div(out_div));
    // Second oscillator proves target separation
    ssp_synth_end #(.DEST_ID(DEST_STROBE)) ssp_synth_end_strobe_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .link(link), .out_oe_n(), .out_sel_ref(), .ctrl_word(strobe_ctrl),
        .word_loaded(), .prog_p(), .prog_q(), .prog_m(), .prog_index(), .vco_mult(), .vco_div(), .out_div());
    ssp_link_sva #(.HALF_CYCLES(HALF)) ssp_link_sva_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .sclk(link.sclk), .sdata(link.sdata), .dest(link.dest));

    // Wire bits as a receiver takes them
    always @(posedge link.sclk) begin
        if (link.dest != 2'h0) begin
            rx_bits.push_back(link.sdata);
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // Classic single cycle; held until ack is sampled, then released
    task automatic wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} <= {2'b11, we, adr, wd, 4'hF};
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack !== 1'b1 && n < 100);
        rd = wb_rdat;
        check(32'(wb_ack), 32'h1, "bus answer");
        {wb_cyc, wb_stb, wb_we} <= 3'h0;
    endtask : wb_cycle

    // Polls a status bit until clear, bounded
    task automatic wait_clear(input int b);
        int n;
        n = 0;
        do begin
            wb_cycle(1'b0, REG_STATUS, 32'h0, st);
            n++;
        end while (st[b] !== 1'b0 && n < 300);
        check(32'(st[b]), 32'h0, "status bit stuck");
    endtask : wait_clear

    task automatic send(input logic [1:0] dst, input logic [2:0] lenx, input logic [26:0] dat);
        rx_bits.delete();
        wb_cycle(1'b1, REG_WORD, {dst, lenx, dat}, st);
        wait_clear(ST_BUSY);
        repeat (8) @(posedge clk_sys);
    endtask : send

    task automatic ctl(input logic [1:0] dst, input logic [7:0] c);
        send(dst, HW_LEN_CTRL, {13'h0000, PROTO_FIELD, c});
    endtask : ctl

    task automatic check_rx(input logic [28:0] exp, input int n);
        check(32'(rx_bits.size()), 32'(n), "bit count");
        for (int i = 0; i < n && i < rx_bits.size(); i++) begin
            check(32'(rx_bits[i]), 32'(exp[i]), "serial bit");
        end
    endtask : check_rx

    task automatic check_out(input logic [7:0] c, input logic oe_n, input logic sel);
        check(32'({ctrl_word, out_oe_n, out_sel_ref}), 32'({c, oe_n, sel}), "output state");
    endtask : check_out

    task automatic check_prog(input logic [6:0] p, input logic [6:0] q, input logic [2:0] m, input logic [3:0] i);
        check(32'({prog_p, prog_q, prog_m, prog_index}), 32'({p, q, m, i}), "word fields");
        check(32'({vco_mult, vco_div, out_div}), 32'({9'(2 * (p + 3)), 8'(q + 2), 8'(1 << m)}), "frequency terms");
    endtask : check_prog

    // Zero after every third one; the run carries over field edges
    function automatic logic [28:0] stuff(input logic [21:0] w, output int n);
        logic [28:0] s;
        int          run;
        s = 29'h0;
        n = 0;
        run = 0;
        for (int i = 0; i < WORD_BITS; i++) begin
            s[n] = w[i];
            n++;
            run = w[i] ? run + 1 : 0;
            if (run == STUFF_RUN) begin
                n++;
                run = 0;
            end
        end
        return s;
    endfunction : stuff

    task automatic prog_word(input logic [6:0] p, input logic [6:0] q, input logic [2:0] m, input logic [3:0] i);
        sw = stuff({p, 1'b0, m, q, i}, sn);
        send(DEST_SAMPLE, 3'(sn - WORD_BITS), 27'(sw));
        check_rx(sw, sn);
    endtask : prog_word

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // Watchdog; the whole sequence needs under two thousand cycles
    initial begin
        repeat (30000) @(posedge clk_sys);
        n_fail++;
        finish_test();
    end

    initial begin
        {reset_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        // Power-up state, idle link, status and an unmapped place
        wb_cycle(1'b0, REG_STATUS, 32'h0, st);
        check(st, 32'h0, "status after reset");
        wb_cycle(1'b0, 4'h8, 32'h0, st);
        check(st, 32'h0, "unmapped read");
        check(32'({link.sclk, link.dest}), 32'h0, "idle link");
        check_out(CTRL_RESET, 1'b0, 1'b1);
        check_prog(7'h00, 7'h00, 3'h0, 4'h0);
        // Enable loading with reference out; other oscillator untouched
        ctl(DEST_SAMPLE, 8'h05);
        check_rx({15'h0000, PROTO_FIELD, 8'h05}, 14);
        check_out(8'h05, 1'b0, 1'b1);
        check(32'(strobe_ctrl), 32'(CTRL_RESET), "other oscillator");
        // Word for 12.8 MHz; fields stay until the commit
        prog_word(7'h38, 7'h1F, 3'h2, 4'h0);
        check({8'(sn), 24'(sw)}, {8'h18, 24'h382370}, "stuffed word");
        check(32'(word_loaded), 32'h1, "word held");
        check_prog(7'h00, 7'h00, 3'h0, 4'h0);
        ctl(DEST_SAMPLE, 8'h04);
        check_out(8'h04, 1'b0, 1'b1);
        check_prog(7'h38, 7'h1F, 3'h2, 4'h0);
        // Switch-over while settling is refused, then accepted
        ctl(DEST_SAMPLE, 8'h00);
        wb_cycle(1'b0, REG_STATUS, 32'h0, st);
        check(32'(st[ST_REFUSED]), 32'h1, "early switch refused");
        check_out(8'h04, 1'b0, 1'b1);
        wb_cycle(1'b1, REG_STATUS, 32'h4, st);
        wait_clear(ST_REFUSED);
        wait_clear(ST_SETTLE);
        ctl(DEST_SAMPLE, 8'h00);
        check_out(8'h00, 1'b0, 1'b0);
        wait_clear(ST_SETTLE);
        ctl(DEST_SAMPLE, 8'h02);
        check_out(8'h02, 1'b1, 1'b0);
        // A word sent while loading is off must not reach the fields
        prog_word(7'h1E, 7'h07, 3'h0, 4'h8);
        ctl(DEST_SAMPLE, 8'h00);
        check_prog(7'h38, 7'h1F, 3'h2, 4'h0);
        // Index top bit one: stuffed zero moves into Q
        ctl(DEST_SAMPLE, 8'h05);
        prog_word(7'h1E, 7'h07, 3'h0, 4'h8);
        ctl(DEST_SAMPLE, 8'h04);
        check_prog(7'h1E, 7'h07, 3'h0, 4'h8);
        // Strobe oscillator, then a write while busy is refused
        ctl(DEST_STROBE, 8'h05);
        check(32'({strobe_ctrl, ctrl_word}), 32'h0504, "target select");
        wb_cycle(1'b1, REG_WORD, {DEST_STROBE, HW_LEN_CTRL, 13'h0000, PROTO_FIELD, 8'h04}, st);
        wb_cycle(1'b1, REG_WORD, {DEST_STROBE, HW_LEN_CTRL, 13'h0000, PROTO_FIELD, 8'h05}, st);
        wb_cycle(1'b0, REG_STATUS, 32'h0, st);
        check(32'(st[ST_REFUSED]), 32'h1, "busy write refused");
        wait_clear(ST_BUSY);
        repeat (8) @(posedge clk_sys);
        check(32'(strobe_ctrl), 32'h4, "only first transfer applied");
        finish_test();
    end
endmodule : synth_serial_programmer_tb_top
`default_nettype wire
